// *** configurable_logic_cell_test.sv ***
// Self-checking bench of the logic cell: APB set-up, random tables.
// Assumes lcl_cell, lcl_link_model and lcl_cfg.svh.
`timescale 1ns/100ps
`default_nettype none
`include "lcl_cfg.svh"

module configurable_logic_cell_test;
    localparam logic [31:0] SRC = 32'h0870_0000; // Enable c3, set/reset c1, in-one c2, direct c0

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd, ct;
    logic        pready, pslverr, err, x_out, y_out, qa_out, qb_out, ea, eb;
    logic [3:0]  f_req = 4'h0, g_req = 4'h0, c_req = 4'h0, f, g, c;
    logic        k_req = 1'b0, gsr_req = 1'b0;
    logic [3:0]  f_pin, g_pin, c_pin;
    logic        k_pin, gsr_pin;
    logic [15:0] ft, gt;
    logic [7:0]  ht;
    int          bad_count = 0, compares = 0, cyc = 0;

    // ----------
    // Clock, instances, timeout
    // ----------
    always #2 clk = ~clk;

    lcl_cell #(.LATCH_OK(1'b1)) u_lcl_cell (.CORE_CLK(clk), .RST(rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .F_IN(f_pin), .G_IN(g_pin),
        .CONTROL_INPUTS(c_pin), .GLOBAL_CLK(k_pin), .GLOBAL_ASYNC_PRESET_CLEAR(gsr_pin),
        .X_OUT(x_out), .Y_OUT(y_out), .REG_OUT_A(qa_out), .REG_OUT_B(qb_out));

    lcl_link_model u_lcl_link_model (.clk(clk), .f_req(f_req), .g_req(g_req), .c_req(c_req),
        .k_req(k_req), .gsr_req(gsr_req), .f_pin(f_pin), .g_pin(g_pin), .c_pin(c_pin),
        .k_pin(k_pin), .gsr_pin(gsr_pin));

    // Cuts a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 12000) begin
            bad_count++;
            complete_run();
        end
    end

    // ----------
    // Tasks and expectations
    // ----------
    task automatic complete_run;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic pulse;
        k_req <= 1'b1;
        repeat (6) @(posedge clk);
        k_req <= 1'b0;
        repeat (6) @(posedge clk);
    endtask

    task automatic tables;
        apb(1'b1, `LCL_OFS_F_TABLE, {16'h0, ft});
        apb(1'b1, `LCL_OFS_G_TABLE, {16'h0, gt});
        apb(1'b1, `LCL_OFS_H_TABLE, {24'h0, ht});
    endtask

    // Combiner output with index {in2, in1, in0}
    function automatic logic hval(logic [31:0] cw, logic [3:0] fi, logic [3:0] gi,
                                  logic [3:0] ci);
        logic [2:0] i;
        i = {cw[`LCL_C_H_USE_F] ? ft[fi] : ci[0], ci[2], cw[`LCL_C_H_USE_G] ? gt[gi] : ci[1]};
        return ht[i];
    endfunction

    // ----------
    // Main sequence
    // ----------
    initial begin
        void'($urandom(32'h5eca));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("outputs after reset", {x_out, y_out, qa_out, qb_out}, 32'h0);
        apb(1'b0, `LCL_OFS_CTRL, 32'h0);
        chk("ctrl reset", rd, `LCL_RST_CTRL);
        apb(1'b1, `LCL_OFS_CTRL, SRC);
        apb(1'b0, `LCL_OFS_CTRL, 32'h0);
        chk("ctrl readback", rd, SRC);
        apb(1'b1, 12'h040, 32'hffff_ffff);
        chk("unmapped error", err, 1'b1);
        $display("test registers done");

        // Random tables and output selections
        for (int i = 0; i < 24; i++) begin
            ct = SRC | ((i < 2) ? 32'hf : 32'($urandom_range(0, 15)));
            ft = 16'($urandom());
            gt = 16'($urandom());
            ht = 8'($urandom());
            f = 4'($urandom());
            g = 4'($urandom());
            c = 4'($urandom());
            tables();
            apb(1'b1, `LCL_OFS_CTRL, ct);
            f_req <= f;
            g_req <= g;
            c_req <= c;
            repeat (6) @(posedge clk);
            ea = ct[`LCL_C_X_SEL_H] ? hval(ct, f, g, c) : ft[f];
            eb = ct[`LCL_C_Y_SEL_H] ? hval(ct, f, g, c) : gt[g];
            chk("x out", x_out, ea);
            chk("y out", y_out, eb);
        end
        $display("test functions done");

        // A from direct data, B from input one through the combiner
        ht = 8'hcc;
        tables();
        apb(1'b1, `LCL_OFS_CTRL, SRC | 32'h1000_00b0);
        ea = 1'b0;
        eb = 1'b0;
        for (int i = 0; i < 16; i++) begin
            c = (i == 0) ? 4'h5 : ((i == 1) ? 4'hd : 4'($urandom()));
            c_req <= c;
            repeat (6) @(posedge clk);
            pulse();
            ea = c[3] ? c[0] : ea;
            eb = c[3] ? c[2] : eb;
            chk("qa stored", qa_out, ea);
            chk("qb stored", qb_out, eb);
        end
        $display("test storage done");

        // Set on A, reset on B: load, local, global
        c_req <= 4'h0;
        apb(1'b1, `LCL_OFS_CTRL, SRC | 32'h0000_0df0);
        @(posedge clk);
        chk("init values", {qa_out, qb_out}, 32'h2);
        c_req <= 4'h1;
        repeat (6) @(posedge clk);
        pulse();
        chk("both direct", {qa_out, qb_out}, 32'h3);
        c_req <= 4'h3;
        repeat (6) @(posedge clk);
        chk("local pulse", {qa_out, qb_out}, 32'h2);
        c_req <= 4'h0;
        repeat (6) @(posedge clk);
        pulse();
        gsr_req <= 1'b1;
        repeat (4) @(posedge clk);
        gsr_req <= 1'b0;
        repeat (6) @(posedge clk);
        chk("global pulse", {qa_out, qb_out}, 32'h2);
        // Both elements to one, then the soft global level
        c_req <= 4'h1;
        repeat (6) @(posedge clk);
        pulse();
        apb(1'b1, `LCL_OFS_GLOBAL, 32'h1);
        apb(1'b0, `LCL_OFS_GLOBAL, 32'h0);
        chk("soft level", rd, 32'h1);
        apb(1'b0, `LCL_OFS_STATUS, 32'h0);
        chk("soft global", rd[1:0], 32'h1);
        apb(1'b1, `LCL_OFS_GLOBAL, 32'h0);
        $display("test set reset done");

        // Feed-through of control inputs
        apb(1'b1, `LCL_OFS_CTRL, 32'h0006_c000);
        for (int i = 0; i < 6; i++) begin
            c = 4'($urandom());
            c_req <= c;
            repeat (6) @(posedge clk);
            chk("feed through", {qa_out, qb_out}, {30'h0, c[2], c[1]});
        end
        $display("test feed through done");

        // Global clock as table input three
        ft = 16'($urandom());
        gt = ~ft;
        tables();
        apb(1'b1, `LCL_OFS_CTRL, 32'h6000_0000);
        f_req <= 4'h5;
        g_req <= 4'ha;
        k_req <= 1'b1;
        repeat (8) @(posedge clk);
        chk("clock into tables", {x_out, y_out}, {30'h0, ft[4'hd], gt[4'ha]});
        k_req <= 1'b0;
        repeat (8) @(posedge clk);
        chk("clock low tables", {x_out, y_out}, {30'h0, ft[4'h5], gt[4'h2]});
        $display("test clock access done");

        // Latch mode on both, transparent while the clock net is high
        apb(1'b1, `LCL_OFS_CTRL, SRC | 32'h0000_30f0);
        k_req <= 1'b1;
        c_req <= 4'h1;
        repeat (8) @(posedge clk);
        chk("latch open", {qa_out, qb_out}, 32'h3);
        c_req <= 4'h0;
        repeat (6) @(posedge clk);
        k_req <= 1'b0;
        repeat (6) @(posedge clk);
        c_req <= 4'h1;
        repeat (6) @(posedge clk);
        chk("latch closed", {qa_out, qb_out}, 32'h0);
        $display("test latch done");
        complete_run();
    end
endmodule
`default_nettype wire

// *** lcl_cell.sv ***
// Configurable logic cell emulated on one core clock, set up over APB.
// Assumes interconnect inputs are asynchronous to CORE_CLK; the global
// clock net arrives as a sampled input and its rising edge is detected.
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "lcl_cfg.svh"

module lcl_cell import lcl_pkg::*; #(
    parameter bit LATCH_OK = 1'b1
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output var  logic [31:0] PRDATA,
    output var  logic        PREADY,
    output var  logic        PSLVERR,
    // Interconnect inputs and outputs of the cell
    input  wire logic [3:0]  F_IN,
    input  wire logic [3:0]  G_IN,
    input  wire logic [3:0]  CONTROL_INPUTS,
    input  wire logic        GLOBAL_CLK,
    input  wire logic        GLOBAL_ASYNC_PRESET_CLEAR,
    output var  logic        X_OUT,
    output var  logic        Y_OUT,
    output var  logic        REG_OUT_A,
    output var  logic        REG_OUT_B
);

    lcl_state_s s_q;
    lcl_state_s s_d;

    logic [3:0] f_sel;
    logic [3:0] g_sel;
    logic [2:0] h_sel;
    logic       f_out;
    logic       g_out;
    logic       h_out;
    logic       clk_en;
    logic       sr_in;
    logic       din;
    logic       aux_input_one;
    logic       clk_edge;
    logic       global_async_preset_clear;
    logic       da;
    logic       db;
    logic       x_nxt;
    logic       y_nxt;
    logic       byp_a;
    logic       byp_b;

    // ----------------------------------------
    // Function generators
    // ----------------------------------------

    // Two four-input tables and the three-input combiner
    lcl_lut #(.N(4)) u_f_lut (
        .tab (s_q.f_tab),
        .sel (f_sel),
        .out (f_out)
    );
    lcl_lut #(.N(4)) u_g_lut (
        .tab (s_q.g_tab),
        .sel (g_sel),
        .out (g_out)
    );
    lcl_lut #(.N(3)) u_h_lut (
        .tab (s_q.h_tab),
        .sel (h_sel),
        .out (h_out)
    );

    // Element update: global or local set/reset beats clocking
    function automatic logic elem_next(
        input logic q,
        input logic d,
        input logic set_val,
        input logic sr_en,
        input logic sr_lcl,
        input logic gsr_in,
        input logic latch,
        input logic edge_in,
        input logic level,
        input logic en
    );
        logic nq;
        nq = q;
        if (gsr_in || (sr_en && sr_lcl)) begin
            nq = set_val;
        end else if (latch && LATCH_OK) begin
            if (level && en) begin
                nq = d;
            end
        end else if (edge_in && en) begin
            nq = d;
        end
        return nq;
    endfunction

    // Data source of a storage element
    function automatic logic dsel(
        input lcl_sel_t sel,
        input logic     f,
        input logic     g,
        input logic     h,
        input logic     dd
    );
        logic r;
        r = dd;
        case (sel)
            `LCL_DSEL_F: r = f;
            `LCL_DSEL_G: r = g;
            `LCL_DSEL_H: r = h;
            default:     r = dd;
        endcase
        return r;
    endfunction

    // ----------------------------------------
    // Cell datapath
    // ----------------------------------------

    // Control mapping, table inputs and element data
    always_comb begin
        clk_en        = s_q.c_s2[s_q.ctrl[`LCL_C_EC_SRC +: 2]]
                        | ~s_q.ctrl[`LCL_C_EC_USE];
        sr_in         = s_q.c_s2[s_q.ctrl[`LCL_C_SR_SRC +: 2]];
        din           = s_q.c_s2[s_q.ctrl[`LCL_C_DIN_SRC +: 2]];
        aux_input_one = s_q.c_s2[s_q.ctrl[`LCL_C_H1_SRC +: 2]];
        f_sel = s_q.f_s2;
        g_sel = s_q.g_s2;
        if (s_q.ctrl[`LCL_C_F_GCLK]) begin
            f_sel[3] = s_q.k_s2;
        end
        if (s_q.ctrl[`LCL_C_G_GCLK]) begin
            g_sel[3] = s_q.k_s2;
        end
        // Input zero shares the set/reset line, input two the direct line
        h_sel[0] = s_q.ctrl[`LCL_C_H_USE_G] ? g_out : sr_in;
        h_sel[1] = aux_input_one;
        h_sel[2] = s_q.ctrl[`LCL_C_H_USE_F] ? f_out : din;
        clk_edge = s_q.k_s2 & ~s_q.k_d;
        global_async_preset_clear      = s_q.gsr_s2 | s_q.soft_gsr;
        // Each element picks its own data: first table, second table, combiner or direct data
        da = dsel(s_q.ctrl[`LCL_C_A_DSEL +: 2], f_out, g_out, h_out, din);
        db = dsel(s_q.ctrl[`LCL_C_B_DSEL +: 2], f_out, g_out, h_out, din);
        x_nxt = s_q.ctrl[`LCL_C_X_SEL_H] ? h_out : f_out;
        y_nxt = s_q.ctrl[`LCL_C_Y_SEL_H] ? h_out : g_out;
        byp_a = s_q.c_s2[s_q.ctrl[`LCL_C_A_BSRC +: 2]];
        byp_b = s_q.c_s2[s_q.ctrl[`LCL_C_B_BSRC +: 2]];
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------

    // Synchronisers, storage elements, outputs and APB slave
    always_comb begin
        s_d = s_q;
        s_d.f_s1   = F_IN;
        s_d.f_s2   = s_q.f_s1;
        s_d.g_s1   = G_IN;
        s_d.g_s2   = s_q.g_s1;
        s_d.c_s1   = CONTROL_INPUTS;
        s_d.c_s2   = s_q.c_s1;
        s_d.k_s1   = GLOBAL_CLK;
        s_d.k_s2   = s_q.k_s1;
        s_d.k_d    = s_q.k_s2;
        s_d.gsr_s1 = GLOBAL_ASYNC_PRESET_CLEAR;
        s_d.gsr_s2 = s_q.gsr_s1;
        // Storage elements, independent of output selection
        s_d.qa = elem_next(s_q.qa, da, s_q.ctrl[`LCL_C_A_SET],
                           s_q.ctrl[`LCL_C_A_SR_EN], sr_in, global_async_preset_clear,
                           s_q.ctrl[`LCL_C_A_LATCH], clk_edge,
                           s_q.k_s2, clk_en);
        s_d.qb = elem_next(s_q.qb, db, s_q.ctrl[`LCL_C_B_SET],
                           s_q.ctrl[`LCL_C_B_SR_EN], sr_in, global_async_preset_clear,
                           s_q.ctrl[`LCL_C_B_LATCH], clk_edge,
                           s_q.k_s2, clk_en);
        // Four cell outputs
        s_d.x      = x_nxt;
        s_d.y      = y_nxt;
        s_d.qa_out = s_q.ctrl[`LCL_C_A_BYP] ? byp_a : s_q.qa;
        s_d.qb_out = s_q.ctrl[`LCL_C_B_BYP] ? byp_b : s_q.qb;
        // Setup phase: decode and arm the answer
        s_d.pready = 1'b0;
        if (PSEL && !PENABLE) begin
            s_d.pready  = 1'b1;
            s_d.pslverr = 1'b0;
            s_d.prdata  = 32'h0000_0000;
            case (PADDR)
                `LCL_OFS_F_TABLE: s_d.prdata = {16'h0000, s_q.f_tab};
                `LCL_OFS_G_TABLE: s_d.prdata = {16'h0000, s_q.g_tab};
                `LCL_OFS_H_TABLE: s_d.prdata = {24'h00_0000, s_q.h_tab};
                `LCL_OFS_CTRL:    s_d.prdata = s_q.ctrl;
                `LCL_OFS_GLOBAL:  s_d.prdata = {31'h0000_0000, s_q.soft_gsr};
                `LCL_OFS_STATUS:  s_d.prdata = {27'h000_0000, s_q.k_s2,
                                                s_q.y, s_q.x, s_q.qb, s_q.qa};
                default:          s_d.pslverr = 1'b1;
            endcase
        end
        // Access phase: a write lands on the answering edge
        if (PSEL && PENABLE && s_q.pready && PWRITE && !s_q.pslverr) begin
            case (PADDR)
                `LCL_OFS_F_TABLE: s_d.f_tab = PWDATA[15:0];
                `LCL_OFS_G_TABLE: s_d.g_tab = PWDATA[15:0];
                `LCL_OFS_H_TABLE: s_d.h_tab = PWDATA[7:0];
                `LCL_OFS_CTRL: begin
                    s_d.ctrl = PWDATA;
                    // New configuration puts each element in its init state
                    s_d.qa = PWDATA[`LCL_C_A_SET];
                    s_d.qb = PWDATA[`LCL_C_B_SET];
                end
                `LCL_OFS_GLOBAL:  s_d.soft_gsr = PWDATA[`LCL_G_SOFT_GSR];
                default:          s_d.soft_gsr = s_q.soft_gsr;
            endcase
        end
        if (!PSEL) begin
            s_d.pslverr = 1'b0;
        end
    end

    // State register
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            s_q      <= '0;
            s_q.ctrl <= `LCL_RST_CTRL;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------

    // All outputs straight from the state register
    assign X_OUT     = s_q.x;
    assign Y_OUT     = s_q.y;
    assign REG_OUT_A = s_q.qa_out;
    assign REG_OUT_B = s_q.qb_out;
    assign PRDATA    = s_q.prdata;
    assign PREADY    = s_q.pready;
    assign PSLVERR   = s_q.pslverr;

    // ----------------------------------------
    // Checks
    // ----------------------------------------

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    sequence apb_setup;
        PSEL && !PENABLE;
    endsequence

    sequence apb_access;
        PSEL && PENABLE && PREADY;
    endsequence

    // Bus answer and configuration
    chk_apb_answer: assert property (apb_setup |=> PREADY)
        else $error("no answer one cycle after setup");

    chk_apb_write_ctrl: assert property (
        apb_setup ##1 (apb_access and (PWRITE && PADDR == `LCL_OFS_CTRL && !PSLVERR))
        |=> s_q.ctrl == $past(PWDATA))
        else $error("control write not stored");

    // Registered output selection
    chk_x_select: assert property (
        s_q.ctrl[`LCL_C_X_SEL_H] && $stable(s_q.ctrl) |=> X_OUT == $past(h_out))
        else $error("X not following combiner");

    chk_x_table: assert property (
        !s_q.ctrl[`LCL_C_X_SEL_H] |=> X_OUT == $past(f_out))
        else $error("X not following first table");

    chk_y_select: assert property (
        !s_q.ctrl[`LCL_C_Y_SEL_H] && $stable(s_q.ctrl) |=> Y_OUT == $past(g_out))
        else $error("Y not following second table");

    chk_y_comb: assert property (
        s_q.ctrl[`LCL_C_Y_SEL_H] |=> Y_OUT == $past(h_out))
        else $error("Y not following combiner");

    // Storage elements
    chk_ff_capture: assert property (
        clk_edge && clk_en && !global_async_preset_clear && !(sr_in && s_q.ctrl[`LCL_C_A_SR_EN])
        && !s_q.ctrl[`LCL_C_A_LATCH] && !(PSEL && PENABLE && PWRITE)
        |=> s_q.qa == $past(da))
        else $error("flip-flop missed enabled edge");

    chk_ff_hold: assert property (
        !clk_edge && !global_async_preset_clear && !sr_in && !s_q.ctrl[`LCL_C_A_LATCH]
        && !(PSEL && PENABLE && PWRITE) |=> $stable(s_q.qa))
        else $error("flip-flop changed without edge");

    chk_gsr_init: assert property (
        s_q.gsr_s2 && !(PSEL && PENABLE && PWRITE)
        |=> s_q.qb == $past(s_q.ctrl[`LCL_C_B_SET])
        ##1 (REG_OUT_B == $past(s_q.qb) || $past(s_q.ctrl[`LCL_C_B_BYP])))
        else $error("global pulse gave wrong state");

    chk_gsr_a: assert property (
        global_async_preset_clear && !(PSEL && PENABLE && PWRITE) |=> s_q.qa == $past(s_q.ctrl[`LCL_C_A_SET]))
        else $error("set or reset gave wrong state on A");

    // Feed-through paths
    chk_bypass_a: assert property (
        s_q.ctrl[`LCL_C_A_BYP] && $stable(s_q.ctrl) |=> REG_OUT_A == $past(byp_a))
        else $error("feed-through path wrong");

    chk_bypass_b: assert property (
        s_q.ctrl[`LCL_C_B_BYP] |=> REG_OUT_B == $past(byp_b))
        else $error("feed-through path wrong on B");

    // Latch option
    chk_latch_follow: assert property (
        LATCH_OK && s_q.ctrl[`LCL_C_B_LATCH] && s_q.k_s2 && clk_en && !global_async_preset_clear
        && !(sr_in && s_q.ctrl[`LCL_C_B_SR_EN]) && !(PSEL && PENABLE && PWRITE)
        |=> s_q.qb == $past(db))
        else $error("open latch not following data");

    chk_latch_a: assert property (
        LATCH_OK && s_q.ctrl[`LCL_C_A_LATCH] && s_q.k_s2 && clk_en && !global_async_preset_clear
        && !(sr_in && s_q.ctrl[`LCL_C_A_SR_EN]) && !(PSEL && PENABLE && PWRITE)
        |=> s_q.qa == $past(da))
        else $error("open latch on A not following data");

endmodule

`default_nettype wire

// *** lcl_cfg.svh ***
// Offsets, field positions and reset values of the logic cell.
// Assumes a 12-bit APB byte address; every register is one aligned word.
`ifndef LCL_CFG_SVH
`define LCL_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LCL_OFS_F_TABLE     12'h000
`define LCL_OFS_G_TABLE     12'h004
`define LCL_OFS_H_TABLE     12'h008
`define LCL_OFS_CTRL        12'h00c
`define LCL_OFS_GLOBAL      12'h010
`define LCL_OFS_STATUS      12'h014

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LCL_RST_TABLE       16'h0000
`define LCL_RST_CTRL        32'h0000_0000

// ----------------------------------------
// Control register fields (lsb positions)
// ----------------------------------------
`define LCL_C_H_USE_F       0
`define LCL_C_H_USE_G       1
`define LCL_C_X_SEL_H       2
`define LCL_C_Y_SEL_H       3
`define LCL_C_A_DSEL        4
`define LCL_C_B_DSEL        6
`define LCL_C_A_SET         8
`define LCL_C_B_SET         9
`define LCL_C_A_SR_EN       10
`define LCL_C_B_SR_EN       11
`define LCL_C_A_LATCH       12
`define LCL_C_B_LATCH       13
`define LCL_C_A_BYP         14
`define LCL_C_B_BYP         15
`define LCL_C_A_BSRC        16
`define LCL_C_B_BSRC        18
`define LCL_C_EC_SRC        20
`define LCL_C_SR_SRC        22
`define LCL_C_DIN_SRC       24
`define LCL_C_H1_SRC        26
`define LCL_C_EC_USE        28
`define LCL_C_F_GCLK        29
`define LCL_C_G_GCLK        30

// ----------------------------------------
// Data select codes and global register bit
// ----------------------------------------
`define LCL_DSEL_F          2'h0
`define LCL_DSEL_G          2'h1
`define LCL_DSEL_H          2'h2
`define LCL_DSEL_DIN        2'h3
`define LCL_G_SOFT_GSR      0

`endif

// *** lcl_link_model.sv ***
// Interconnect model driving the user-side inputs of the logic cell.
// Assumes bench requests; pins follow one core cycle later, the clock pin no sooner than two cycles after its last change.
`timescale 1ns/100ps
`default_nettype none

module lcl_link_model (
    input  wire logic       clk,
    input  wire logic [3:0] f_req,
    input  wire logic [3:0] g_req,
    input  wire logic [3:0] c_req,
    input  wire logic       k_req,
    input  wire logic       gsr_req,
    output var  logic [3:0] f_pin,
    output var  logic [3:0] g_pin,
    output var  logic [3:0] c_pin,
    output var  logic       k_pin,
    output var  logic       gsr_pin
);
    logic [1:0] k_age; // Cycles the clock net has held its level

    // ----------
    // Pins
    // ----------
    // Known levels from time zero
    initial begin
        f_pin = 4'h0;
        g_pin = 4'h0;
        c_pin = 4'h0;
        k_pin = 1'b0;
        gsr_pin = 1'b0;
        k_age = 2'h0;
    end

    // Clock net keeps each level at least two core cycles
    always @(posedge clk) begin
        f_pin <= f_req;
        g_pin <= g_req;
        c_pin <= c_req;
        gsr_pin <= gsr_req;
        if (k_req != k_pin && k_age >= 2'h1) begin
            k_pin <= k_req;
            k_age <= 2'h0;
        end else if (k_age != 2'h3) begin
            k_age <= k_age + 2'h1;
        end
    end
endmodule
`default_nettype wire

// *** lcl_lut.sv ***
// Look-up function generator: any Boolean function of N inputs.
// Assumes the table is held by the caller; purely combinational.
`timescale 1ns/100ps
`default_nettype none

module lcl_lut #(
    parameter int N = 4
) (
    input  wire logic [(1<<N)-1:0] tab,
    input  wire logic [N-1:0]      sel,
    output var  logic              out
);

    // Table bit picked by the input pattern
    always_comb begin
        out = tab[sel];
    end

endmodule

`default_nettype wire

// *** lcl_pkg.sv ***
// Types shared by the logic cell modules.
// Assumes lcl_cfg.svh for all numeric constants.
package lcl_pkg;

    typedef logic [15:0] lcl_table_t;
    typedef logic [1:0]  lcl_sel_t;

    // ----------------------------------------
    // Whole state of the cell top
    // ----------------------------------------
    typedef struct packed {
        logic [3:0]  f_s1;
        logic [3:0]  f_s2;
        logic [3:0]  g_s1;
        logic [3:0]  g_s2;
        logic [3:0]  c_s1;
        logic [3:0]  c_s2;
        logic        k_s1;
        logic        k_s2;
        logic        k_d;
        logic        gsr_s1;
        logic        gsr_s2;
        lcl_table_t  f_tab;
        lcl_table_t  g_tab;
        logic [7:0]  h_tab;
        logic [31:0] ctrl;
        logic        soft_gsr;
        logic        qa;
        logic        qb;
        logic        x;
        logic        y;
        logic        qa_out;
        logic        qb_out;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } lcl_state_s;

endpackage
